// ==== crcb_map.vh ====
`ifndef CRCB_MAP_VH
`define CRCB_MAP_VH
// opcodes
`define CRCB_OP_RLC_CIRC   8'h07
`define CRCB_OP_RRC_CIRC   8'h0F
`define CRCB_OP_RL_CARRY   8'h17
`define CRCB_OP_RR_CARRY   8'h1F
`define CRCB_OP_CPL_ACC    8'h2F
`define CRCB_OP_SET_CY     8'h37
`define CRCB_OP_CPL_CY     8'h3F
`define CRCB_OP_CMP_MEM    8'hBE
`define CRCB_OP_JUMP       8'hC3
`define CRCB_OP_CALL       8'hCD
`define CRCB_OP_EXIT       8'hC9
// conditional opcode families: bits 7:6 and 2:0, condition in 5:3
`define CRCB_FAM_JCOND     3'h2
`define CRCB_FAM_CCOND     3'h4
`define CRCB_HI_BRANCH     2'h3
// condition field codes
`define CRCB_CC_NZ         3'h0
`define CRCB_CC_Z          3'h1
`define CRCB_CC_NC         3'h2
`define CRCB_CC_C          3'h3
`define CRCB_CC_PO         3'h4
`define CRCB_CC_PE         3'h5
`define CRCB_CC_P          3'h6
`define CRCB_CC_M          3'h7
// flag vector bit positions {s,z,ac,p,cy}
`define CRCB_F_CY          0
`define CRCB_F_P           1
`define CRCB_F_AC          2
`define CRCB_F_Z           3
`define CRCB_F_S           4
// counts
`define CRCB_ONE16         16'h0001
`define CRCB_TWO16         16'h0002
`define CRCB_ST_W          3
`endif

// ==== crcb_exec.v ====
`timescale 1ns/1ns
`include "crcb_map.vh"
module crcb_exec (
    input  wire        mclk,
    input  wire        sys_rst,
    input  wire        instr_valid,
    input  wire [7:0]  instr_opcode,
    input  wire [15:0] next_pc,
    input  wire [15:0] hl_pair,
    input  wire [15:0] pc_init,
    input  wire [15:0] sp_init,
    input  wire        mem_ready,
    input  wire [7:0]  mem_rdata,
    output wire        instr_ready,
    output reg         done_ff,
    output reg         unknown_ff,
    output reg         mem_req_ff,
    output reg         mem_we_ff,
    output reg  [15:0] mem_addr_ff,
    output reg  [7:0]  mem_wdata_ff,
    output reg  [7:0]  acc_ff,
    output reg  [4:0]  flags_ff,
    output reg  [15:0] program_counter_ff,
    output reg  [15:0] stack_pointer_ff
);
    localparam [2:0] ST_IDLE = 3'h0;
    localparam [2:0] ST_LO   = 3'h1;
    localparam [2:0] ST_HI   = 3'h2;
    localparam [2:0] ST_PUSH = 3'h3;
    localparam [2:0] ST_PUSL = 3'h4;
    localparam [2:0] ST_POPL = 3'h5;
    localparam [2:0] ST_POPH = 3'h6;
    localparam [2:0] ST_CMP  = 3'h7;
    // jump: ST_LO, ST_HI fetch the target bytes
    // call: as jump, then ST_PUSH, ST_PUSL write the return address
    // exit: ST_POPL, ST_POPH read it back; compare: one read in ST_CMP

    reg [`CRCB_ST_W-1:0] st_ff;
    reg [7:0]            lo_ff;
    reg [15:0]           ret_ff;
    reg                  is_call_ff;

    reg [`CRCB_ST_W-1:0] nxt_st;
    reg [7:0]            nxt_acc;
    reg [4:0]            nxt_flags;
    reg [15:0]           nxt_pc;
    reg [15:0]           nxt_sp;
    reg [7:0]            nxt_lo;
    reg [15:0]           nxt_ret;
    reg                  nxt_is_call;
    reg                  nxt_done;
    reg                  nxt_unknown;
    reg                  nxt_req;
    reg                  nxt_we;
    reg [15:0]           nxt_addr;
    reg [7:0]            nxt_wdata;
    reg                  cond_true;
    reg [8:0]            diff;
    reg                  cmp_zero;
    reg                  cmp_borrow;
    reg                  cmp_sign;
    reg                  cmp_parity;
    reg                  cmp_half;

    wire [2:0] ccc = instr_opcode[5:3];
    wire [1:0] ophi = instr_opcode[7:6];
    wire [2:0] oplo = instr_opcode[2:0];
    wire       bus_done = mem_req_ff & mem_ready;
    wire       is_jcond = (ophi == `CRCB_HI_BRANCH) & (oplo == `CRCB_FAM_JCOND);
    wire       is_ccond = (ophi == `CRCB_HI_BRANCH) & (oplo == `CRCB_FAM_CCOND);
    // return address of a call: the byte after both address bytes
    wire [15:0] ret_addr = ret_ff + `CRCB_TWO16;

    assign instr_ready = (st_ff == ST_IDLE) & ~mem_req_ff;

    always @* begin
        case (ccc)
            `CRCB_CC_NZ: cond_true = ~flags_ff[`CRCB_F_Z];
            `CRCB_CC_Z:  cond_true =  flags_ff[`CRCB_F_Z];
            `CRCB_CC_NC: cond_true = ~flags_ff[`CRCB_F_CY];
            `CRCB_CC_C:  cond_true =  flags_ff[`CRCB_F_CY];
            `CRCB_CC_PO: cond_true = ~flags_ff[`CRCB_F_P];
            `CRCB_CC_PE: cond_true =  flags_ff[`CRCB_F_P];
            `CRCB_CC_P:  cond_true = ~flags_ff[`CRCB_F_S];
            default:     cond_true =  flags_ff[`CRCB_F_S];
        endcase
    end

    // flags of acc minus memory byte; the difference itself is dropped
    always @* begin
        diff       = {1'b0, acc_ff} - {1'b0, mem_rdata};
        cmp_zero   = diff[7:0] == 8'h00;
        cmp_borrow = diff[8];
        cmp_sign   = diff[7];
        cmp_parity = ~^diff[7:0];
        cmp_half   = acc_ff[3:0] < mem_rdata[3:0];
    end

    // next-state logic; registers hold unless a path below moves them, but done and unknown default low and the request drops on mem_ready
    always @* begin
        nxt_st      = st_ff;
        nxt_acc     = acc_ff;
        nxt_flags   = flags_ff;
        nxt_pc      = program_counter_ff;
        nxt_sp      = stack_pointer_ff;
        nxt_lo      = lo_ff;
        nxt_ret     = ret_ff;
        nxt_is_call = is_call_ff;
        nxt_done    = 1'b0;
        nxt_unknown = 1'b0;
        nxt_req     = mem_req_ff & ~mem_ready;
        nxt_we      = mem_we_ff;
        nxt_addr    = mem_addr_ff;
        nxt_wdata   = mem_wdata_ff;
        case (st_ff)
            ST_IDLE: begin
                if (instr_valid & instr_ready) begin
                    nxt_ret     = next_pc;
                    nxt_pc      = next_pc;
                    nxt_is_call = 1'b0;
                    nxt_done    = 1'b1;
                    case (instr_opcode)
                        `CRCB_OP_RLC_CIRC: begin
                            nxt_acc = {acc_ff[6:0], acc_ff[7]};
                            nxt_flags[`CRCB_F_CY] = acc_ff[7];
                        end
                        `CRCB_OP_RRC_CIRC: begin
                            nxt_acc = {acc_ff[0], acc_ff[7:1]};
                            nxt_flags[`CRCB_F_CY] = acc_ff[0];
                        end
                        `CRCB_OP_RL_CARRY: begin
                            nxt_acc = {acc_ff[6:0], flags_ff[`CRCB_F_CY]};
                            nxt_flags[`CRCB_F_CY] = acc_ff[7];
                        end
                        `CRCB_OP_RR_CARRY: begin
                            nxt_acc = {flags_ff[`CRCB_F_CY], acc_ff[7:1]};
                            nxt_flags[`CRCB_F_CY] = acc_ff[0];
                        end
                        `CRCB_OP_CPL_CY:  nxt_flags[`CRCB_F_CY] = ~flags_ff[`CRCB_F_CY];
                        `CRCB_OP_SET_CY:  nxt_flags[`CRCB_F_CY] = 1'b1;
                        `CRCB_OP_CPL_ACC: nxt_acc = ~acc_ff;
                        `CRCB_OP_CMP_MEM: begin
                            nxt_done = 1'b0;
                            nxt_st   = ST_CMP;
                            nxt_req  = 1'b1;
                            nxt_we   = 1'b0;
                            nxt_addr = hl_pair;
                        end
                        `CRCB_OP_EXIT: begin
                            nxt_done = 1'b0;
                            nxt_st   = ST_POPL;
                            nxt_req  = 1'b1;
                            nxt_we   = 1'b0;
                            nxt_addr = stack_pointer_ff;
                        end
                        `CRCB_OP_JUMP, `CRCB_OP_CALL: begin
                            nxt_done    = 1'b0;
                            nxt_is_call = instr_opcode == `CRCB_OP_CALL;
                            nxt_st      = ST_LO;
                            nxt_req     = 1'b1;
                            nxt_we      = 1'b0;
                            nxt_addr    = next_pc;
                        end
                        default: begin
                            if (is_jcond | is_ccond) begin
                                if (cond_true) begin
                                    nxt_done    = 1'b0;
                                    nxt_is_call = is_ccond;
                                    nxt_st      = ST_LO;
                                    nxt_req     = 1'b1;
                                    nxt_we      = 1'b0;
                                    nxt_addr    = next_pc;
                                end else begin
                                    // fall through past both address bytes
                                    nxt_pc = next_pc + `CRCB_TWO16;
                                end
                            end else begin
                                // opcodes outside this group are flagged for the rest of the core
                                nxt_unknown = 1'b1;
                            end
                        end
                    endcase
                    // memory ops move the program counter only when they finish
                    if (nxt_st != ST_IDLE) begin
                        nxt_pc = program_counter_ff;
                    end
                end
            end
            ST_LO: if (bus_done) begin
                nxt_lo   = mem_rdata;
                nxt_st   = ST_HI;
                nxt_req  = 1'b1;
                nxt_addr = mem_addr_ff + `CRCB_ONE16;
            end
            ST_HI: if (bus_done) begin
                if (is_call_ff) begin
                    nxt_ret   = {mem_rdata, lo_ff};
                    nxt_lo    = ret_addr[7:0];
                    nxt_st    = ST_PUSH;
                    nxt_req   = 1'b1;
                    nxt_we    = 1'b1;
                    nxt_addr  = stack_pointer_ff - `CRCB_ONE16;
                    nxt_wdata = ret_addr[15:8];
                end else begin
                    // jump target lands only after its high byte
                    nxt_pc   = {mem_rdata, lo_ff};
                    nxt_st   = ST_IDLE;
                    nxt_done = 1'b1;
                end
            end
            ST_PUSH: if (bus_done) begin
                nxt_st    = ST_PUSL;
                nxt_req   = 1'b1;
                nxt_we    = 1'b1;
                nxt_addr  = stack_pointer_ff - `CRCB_TWO16;
                nxt_wdata = lo_ff;
            end
            ST_PUSL: if (bus_done) begin
                nxt_we   = 1'b0;
                nxt_sp   = stack_pointer_ff - `CRCB_TWO16;
                nxt_pc   = ret_ff;
                nxt_st   = ST_IDLE;
                nxt_done = 1'b1;
            end
            ST_POPL: if (bus_done) begin
                nxt_lo   = mem_rdata;
                nxt_st   = ST_POPH;
                nxt_req  = 1'b1;
                nxt_addr = stack_pointer_ff + `CRCB_ONE16;
            end
            ST_POPH: if (bus_done) begin
                nxt_pc   = {mem_rdata, lo_ff};
                nxt_sp   = stack_pointer_ff + `CRCB_TWO16;
                nxt_st   = ST_IDLE;
                nxt_done = 1'b1;
            end
            ST_CMP: if (bus_done) begin
                nxt_flags[`CRCB_F_Z]  = cmp_zero;
                nxt_flags[`CRCB_F_CY] = cmp_borrow;
                nxt_flags[`CRCB_F_S]  = cmp_sign;
                nxt_flags[`CRCB_F_P]  = cmp_parity;
                nxt_flags[`CRCB_F_AC] = cmp_half;
                nxt_pc   = ret_ff;
                nxt_st   = ST_IDLE;
                nxt_done = 1'b1;
            end
            // all eight state codes are decoded above, so this recovery to idle is never reached
            default: nxt_st = ST_IDLE;
        endcase
    end

    // branch states never write nxt_flags, so flags hold across them
    always @(posedge mclk) begin
        if (sys_rst) begin
            st_ff              <= ST_IDLE;
            acc_ff             <= 8'h00;
            flags_ff           <= 5'h00;
            program_counter_ff <= pc_init;
            stack_pointer_ff   <= sp_init;
            lo_ff              <= 8'h00;
            ret_ff             <= 16'h0000;
            is_call_ff         <= 1'b0;
            done_ff            <= 1'b0;
            unknown_ff         <= 1'b0;
            mem_req_ff         <= 1'b0;
            mem_we_ff          <= 1'b0;
            mem_addr_ff        <= 16'h0000;
            mem_wdata_ff       <= 8'h00;
        end else begin
            st_ff              <= nxt_st;
            acc_ff             <= nxt_acc;
            flags_ff           <= nxt_flags;
            program_counter_ff <= nxt_pc;
            stack_pointer_ff   <= nxt_sp;
            lo_ff              <= nxt_lo;
            ret_ff             <= nxt_ret;
            is_call_ff         <= nxt_is_call;
            done_ff            <= nxt_done;
            unknown_ff         <= nxt_unknown;
            mem_req_ff         <= nxt_req;
            mem_we_ff          <= nxt_we;
            mem_addr_ff        <= nxt_addr;
            mem_wdata_ff       <= nxt_wdata;
        end
    end
endmodule

// ==== crcb_checker.sv ====
`timescale 1ns/1ns
`include "crcb_map.vh"
module crcb_checker (
    input wire        mclk,
    input wire        sys_rst,
    input wire        instr_valid,
    input wire [7:0]  instr_opcode,
    input wire        instr_ready,
    input wire        done_ff,
    input wire        mem_ready,
    input wire        mem_req_ff,
    input wire        mem_we_ff,
    input wire [15:0] mem_addr_ff,
    input wire [7:0]  acc_ff,
    input wire [4:0]  flags_ff,
    input wire [15:0] program_counter_ff
);
    wire       take = instr_valid && instr_ready;
    wire [7:0] op   = instr_opcode;
    wire [7:0] av   = acc_ff;
    wire       cy   = flags_ff[0];
    wire       branch = op == `CRCB_OP_JUMP || op == `CRCB_OP_CALL || op == `CRCB_OP_EXIT
        || (op[7:6] == 2'h3 && (op[2:0] == `CRCB_FAM_JCOND || op[2:0] == `CRCB_FAM_CCOND));
    default clocking dcb @(posedge mclk); endclocking
    default disable iff (sys_rst);
    // one-byte ops finish next cycle with only carry free to move
    property p_one(code, nacc, ncy);
        take && op == code |=> done_ff && acc_ff == nacc && flags_ff == {$past(flags_ff[4:1]), ncy};
    endproperty
    a_rotl_circ: assert property (p_one(`CRCB_OP_RLC_CIRC, $past({av[6:0], av[7]}), $past(av[7])))
        else $error("rotate left circular wrong");
    a_rotr_circ: assert property (p_one(`CRCB_OP_RRC_CIRC, $past({av[0], av[7:1]}), $past(av[0])))
        else $error("rotate right circular wrong");
    a_rotl_carry: assert property (p_one(`CRCB_OP_RL_CARRY, $past({av[6:0], cy}), $past(av[7])))
        else $error("rotate left through carry wrong");
    a_rotr_carry: assert property (p_one(`CRCB_OP_RR_CARRY, $past({cy, av[7:1]}), $past(av[0])))
        else $error("rotate right through carry wrong");
    a_cpl_carry: assert property (p_one(`CRCB_OP_CPL_CY, $past(av), !$past(cy)))
        else $error("carry complement wrong");
    a_set_carry: assert property (p_one(`CRCB_OP_SET_CY, $past(av), 1'b1))
        else $error("carry set wrong");
    a_cpl_acc: assert property (p_one(`CRCB_OP_CPL_ACC, $past(~av), $past(cy)))
        else $error("accumulator complement wrong");
    a_cmp_keeps_acc: assert property (take && op == `CRCB_OP_CMP_MEM |=> $stable(av) throughout ##[0:20] done_ff)
        else $error("compare changed accumulator or never finished");
    a_branch_flags: assert property (take && branch |=> $stable(flags_ff) [*2])
        else $error("branch altered flags");
    a_pc_last: assert property ($changed(program_counter_ff) |-> done_ff)
        else $error("program counter moved before completion");
    a_mem_hold: assert property (mem_req_ff && !mem_ready |=> mem_req_ff && $stable({mem_addr_ff, mem_we_ff}))
        else $error("memory request dropped or changed");
    c_call: cover property (take && op == `CRCB_OP_CALL);
    c_push: cover property (mem_req_ff && mem_we_ff && mem_ready);
    c_cmp: cover property (take && op == `CRCB_OP_CMP_MEM);
endmodule
bind crcb_exec crcb_checker u_chk (
    .mclk(mclk), .sys_rst(sys_rst), .instr_valid(instr_valid), .instr_opcode(instr_opcode),
    .instr_ready(instr_ready), .done_ff(done_ff), .mem_ready(mem_ready), .mem_req_ff(mem_req_ff),
    .mem_we_ff(mem_we_ff), .mem_addr_ff(mem_addr_ff), .acc_ff(acc_ff), .flags_ff(flags_ff),
    .program_counter_ff(program_counter_ff)
);

// ==== tb_cpu_rotate_compare_branch.sv ====
`timescale 1ns/1ns
`include "crcb_map.vh"
module tb_cpu_rotate_compare_branch;
    reg         mclk = 1'b0;
    reg         sys_rst = 1'b1;
    reg         instr_valid = 1'b0;
    reg  [7:0]  instr_opcode = 8'h00;
    reg  [15:0] next_pc = 16'h0000;
    reg  [15:0] hl_pair = 16'h0000;
    reg         mem_ready = 1'b0;
    reg  [7:0]  mem_rdata = 8'h00;
    wire        instr_ready, done_ff, mem_req_ff, mem_we_ff, unknown_ff;
    wire [15:0] mem_addr_ff, program_counter_ff, stack_pointer_ff;
    wire [7:0]  mem_wdata_ff, acc_ff;
    wire [4:0]  flags_ff;
    reg  [7:0]  mem [0:65535];
    reg  [7:0]  e_acc = 8'h00;
    reg  [4:0]  e_fl = 5'h00;
    reg  [7:0]  diff;
    reg  [2:0]  cc;
    reg  [15:0] np;
    reg         tk;
    reg  [95:0] seq = {`CRCB_OP_CPL_ACC, `CRCB_OP_RR_CARRY, `CRCB_OP_RLC_CIRC, `CRCB_OP_SET_CY,
        `CRCB_OP_RL_CARRY, `CRCB_OP_RRC_CIRC, `CRCB_OP_CPL_CY, `CRCB_OP_RR_CARRY,
        `CRCB_OP_CPL_ACC, `CRCB_OP_RL_CARRY, `CRCB_OP_CPL_CY, `CRCB_OP_RRC_CIRC};
    integer     n_mismatch = 0;
    integer     num_checks = 0;
    integer     cyc = 0;
    integer     i;
    always #50 mclk = ~mclk;
    crcb_exec u_dut (.mclk(mclk), .sys_rst(sys_rst), .instr_valid(instr_valid), .instr_opcode(instr_opcode),
        .next_pc(next_pc), .hl_pair(hl_pair), .pc_init(16'h0000), .sp_init(16'h0000), .mem_ready(mem_ready),
        .mem_rdata(mem_rdata), .instr_ready(instr_ready), .done_ff(done_ff), .unknown_ff(unknown_ff),
        .mem_req_ff(mem_req_ff), .mem_we_ff(mem_we_ff), .mem_addr_ff(mem_addr_ff), .mem_wdata_ff(mem_wdata_ff),
        .acc_ff(acc_ff), .flags_ff(flags_ff), .program_counter_ff(program_counter_ff),
        .stack_pointer_ff(stack_pointer_ff));
    // memory answers at the negedge after a request meets mem_ready low; read data scrambles when idle
    always @(negedge mclk) begin
        if (mem_req_ff && !mem_ready) begin
            mem_ready <= 1'b1;
            mem_rdata <= mem[mem_addr_ff];
            if (mem_we_ff) mem[mem_addr_ff] <= mem_wdata_ff;
        end else begin
            mem_ready <= 1'b0;
            mem_rdata <= ~mem_rdata;
        end
    end
    always @(posedge mclk) begin
        cyc = cyc + 1;
        if (cyc == 5000) begin
            n_mismatch = n_mismatch + 1;
            tally_and_finish;
        end
    end
    task tally_and_finish;
        begin
            $display("checks %0d mismatches %0d", num_checks, n_mismatch);
            if (n_mismatch == 0 && num_checks > 0) $display("SIMULATION PASSED");
            else $display("SIMULATION FAILED");
            $finish;
        end
    endtask
    task chk(input [63:0] what, input [15:0] exp, input [15:0] got);
        begin
            num_checks = num_checks + 1;
            if (got !== exp) begin
                n_mismatch = n_mismatch + 1;
                $display("MISMATCH %0s expected %h seen %h", what, exp, got);
            end
        end
    endtask
    task exec(input [7:0] op, input [15:0] npc);
        integer k;
        begin
            k = 0;
            @(negedge mclk);
            while (!instr_ready && k < 50) begin
                @(negedge mclk);
                k = k + 1;
            end
            instr_valid = 1'b1;
            instr_opcode = op;
            next_pc = npc;
            @(negedge mclk);
            instr_valid = 1'b0;
            while (done_ff !== 1'b1 && k < 100) begin
                @(negedge mclk);
                k = k + 1;
            end
            chk("done", 16'h0001, {15'h0000, done_ff});
        end
    endtask
    task one(input [7:0] op);
        begin
            case (op)
                `CRCB_OP_RLC_CIRC: {e_acc, e_fl[0]} = {e_acc[6:0], e_acc[7], e_acc[7]};
                `CRCB_OP_RRC_CIRC: {e_acc, e_fl[0]} = {e_acc[0], e_acc[7:1], e_acc[0]};
                `CRCB_OP_RL_CARRY: {e_acc, e_fl[0]} = {e_acc[6:0], e_fl[0], e_acc[7]};
                `CRCB_OP_RR_CARRY: {e_acc, e_fl[0]} = {e_fl[0], e_acc[7:1], e_acc[0]};
                `CRCB_OP_CPL_CY: e_fl[0] = ~e_fl[0];
                `CRCB_OP_SET_CY: e_fl[0] = 1'b1;
                default: e_acc = ~e_acc;
            endcase
            exec(op, 16'h0000);
            chk("acc", e_acc, acc_ff);
            chk("flags", e_fl & 5'h1B, flags_ff & 5'h1B);
            chk("unknown", 16'h0000, {15'h0000, unknown_ff});
        end
    endtask
    task cmp(input [7:0] v);
        begin
            hl_pair = hl_pair + 16'h0101;
            mem[hl_pair] = v;
            diff = e_acc - v;
            e_fl = {diff[7], e_acc == v, e_fl[2], ~^diff, e_acc < v};
            exec(`CRCB_OP_CMP_MEM, hl_pair + 16'h0001);
            chk("acc", e_acc, acc_ff);
            chk("pc", hl_pair + 16'h0001, program_counter_ff);
            chk("flags", e_fl & 5'h1B, flags_ff & 5'h1B);
        end
    endtask
    task br(input [7:0] op, input [15:0] npc, input [15:0] epc, input [15:0] esp);
        begin
            exec(op, npc);
            chk("pc", epc, program_counter_ff);
            chk("sp", esp, stack_pointer_ff);
            chk("flags", e_fl & 5'h1B, flags_ff & 5'h1B);
        end
    endtask
    initial begin
        repeat (10) @(negedge mclk);
        sys_rst = 1'b0;
        chk("pc", 16'h0000, program_counter_ff);
        chk("sp", 16'h0000, stack_pointer_ff);
        chk("flags", 16'h0000, {11'h000, flags_ff});
        for (i = 11; i >= 0; i = i - 1) one(seq[8 * i +: 8]);
        exec(8'hC0, 16'h0000);
        chk("unknown", 16'h0001, {15'h0000, unknown_ff});
        chk("flags", e_fl & 5'h1B, flags_ff & 5'h1B);
        $display("test rotates ended");
        cmp(8'h00);
        cmp(8'h01);
        one(`CRCB_OP_CPL_ACC);
        cmp(8'h10);
        $display("test compare ended");
        for (i = 0; i < 8; i = i + 1) begin
            cc = i[2:0];
            np = {8'h20, 1'b0, cc, 4'h0};
            mem[np] = {5'h0A, cc};
            mem[np + 16'h0001] = 8'h5C;
            tk = (cc[2:1] == 2'h0 ? e_fl[3] : cc[2:1] == 2'h1 ? e_fl[0] : cc[2:1] == 2'h2 ? e_fl[1] : e_fl[4]) == cc[0];
            br({2'h3, cc, `CRCB_FAM_JCOND}, np, tk ? {8'h5C, 5'h0A, cc} : np + 16'h0002, 16'h0000);
        end
        mem[16'h1000] = 8'h21;
        mem[16'h1001] = 8'h43;
        br(`CRCB_OP_JUMP, 16'h1000, 16'h4321, 16'h0000);
        $display("test jumps ended");
        mem[16'h3000] = 8'h78;
        mem[16'h3001] = 8'h56;
        mem[16'h3100] = 8'h9A;
        mem[16'h3101] = 8'hBC;
        br(`CRCB_OP_CALL, 16'h3000, 16'h5678, 16'hFFFE);
        chk("push_hi", 16'h0030, {8'h00, mem[16'hFFFF]});
        chk("push_lo", 16'h0002, {8'h00, mem[16'hFFFE]});
        br({2'h3, `CRCB_CC_C, `CRCB_FAM_CCOND}, 16'h3100, 16'h3102, 16'hFFFE);
        br({2'h3, `CRCB_CC_NC, `CRCB_FAM_CCOND}, 16'h3100, 16'hBC9A, 16'hFFFC);
        chk("push_hi", 16'h0031, {8'h00, mem[16'hFFFD]});
        chk("push_lo", 16'h0002, {8'h00, mem[16'hFFFC]});
        br(`CRCB_OP_EXIT, 16'h0000, 16'h3102, 16'hFFFE);
        br(`CRCB_OP_EXIT, 16'h0000, 16'h3002, 16'h0000);
        $display("test calls ended");
        tally_and_finish;
    end
endmodule
